// ### hdl/cpdma_pkg.sv
// cpdma_pkg: register map, field positions, reset values and types for the
// channel-pair dma engine; shared by the engine and the verification side.
package cpdma_pkg;
  localparam logic [11:0] CPDMA_OFF_RX_CUR_PTR = 12'h100;
  localparam logic [11:0] CPDMA_OFF_RX_CUR_CNT = 12'h104;
  localparam logic [11:0] CPDMA_OFF_TX_CUR_PTR = 12'h108;
  localparam logic [11:0] CPDMA_OFF_TX_CUR_CNT = 12'h10c;
  localparam logic [11:0] CPDMA_OFF_RX_NXT_PTR = 12'h110;
  localparam logic [11:0] CPDMA_OFF_RX_NXT_CNT = 12'h114;
  localparam logic [11:0] CPDMA_OFF_TX_NXT_PTR = 12'h118;
  localparam logic [11:0] CPDMA_OFF_TX_NXT_CNT = 12'h11c;
  localparam logic [11:0] CPDMA_OFF_CTRL = 12'h120;
  localparam logic [11:0] CPDMA_OFF_STATUS = 12'h124;
  // transfer size register: bits [1:0] rx size, [3:2] tx size
  localparam logic [11:0] CPDMA_OFF_SIZE = 12'h128;
  // control / status bit positions
  localparam int CPDMA_BIT_RX_ON = 0;
  localparam int CPDMA_BIT_RX_OFF = 1;
  localparam int CPDMA_BIT_TX_ON = 8;
  localparam int CPDMA_BIT_TX_OFF = 9;
  localparam int CPDMA_BIT_RX_SIZE = 0;
  localparam int CPDMA_BIT_TX_SIZE = 2;
  localparam logic [31:0] CPDMA_PTR_RESET = 32'h0000_0000;
  localparam logic [15:0] CPDMA_CNT_RESET = 16'h0000;
  localparam logic [1:0] CPDMA_SIZE_RESET = 2'h0;
  // size codes
  localparam logic [1:0] CPDMA_SIZE_BYTE = 2'h0;
  localparam logic [1:0] CPDMA_SIZE_HALF = 2'h1;
  localparam logic [1:0] CPDMA_SIZE_WORD = 2'h2;
  localparam logic [1:0] CPDMA_RESP_OKAY = 2'h0;
  localparam logic [1:0] CPDMA_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CPDMA_IDLE, CPDMA_BUS_REQ, CPDMA_RD, CPDMA_WR, CPDMA_DONE
  } cpdma_state_t;
endpackage

// ### hdl/cpdma_top.sv
// cpdma_top: one receive and one transmit channel_pair_dma channel for one
// serial peripheral, registers over axi4-lite, a simple bus master port.
// assumes: one clock, the peripheral triggers are level requests from a
// foreign domain, and the system bus answers each access with a done pulse.
// Function
// - one rx channel and one tx channel serve the single peripheral
// - pointer/count registers sit from offset 0x100, pointers 32 bit, counts 16 bit
// - current pointer and count read back live values at any time
// - set/clear control bits enable each direction; status readable; disabled freezes (code: a request captured before the disable still transfers)
// - rx end flag raised when rx current count is zero
// - rx buffers-full flag raised when rx current and next count both zero
// - tx end flag raised when tx current count is zero
// - tx buffers-empty flag raised when tx current and next count both zero
// - pointer advances by 1, 2 or 4 per byte, half-word or word transfer
// - software write of current pointer is used for following transfers
// - current count decrements per transfer; at zero the channel stops
// - count zero and next zero: trigger ignored and end flag raised
// - software write of current count restarts countdown from new value
// - count zero, next nonzero: next pointer and count load into current (code: only as the last transfer empties current)
// - next count clears to zero when it is loaded into current
// - any write to current or next count clears that channel's end flag (code: flag is current count == 0, cleared only by a nonzero current count)
// - rx: request bus, read receive holding register, write memory at pointer
// - tx: request bus, read memory at pointer, write transmit holding register
// - block fully transferred: signal peripheral and stop channel
// - requests served in arrival order; pending rx before pending tx
// - control register: rx on only if rx off not written; zero bits no effect
// - status register at 0x124 shows rx and tx enable, resets to zero
`timescale 1ns/1ps
module cpdma_top
  import cpdma_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // axi4-lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // peripheral side
  input wire logic rx_ready_trigger,
  input wire logic tx_ready_trigger,
  output logic rx_end_of_buffer,
  output logic rx_buffers_full,
  output logic tx_end_of_buffer,
  output logic tx_buffers_empty,
  // system bus master
  output logic sys_bus_req,
  input wire logic sys_bus_grant,
  output logic sys_rd,
  output logic sys_wr,
  output logic sys_periph,
  output logic [31:0] sys_addr,
  output logic [1:0] sys_size,
  output logic [31:0] sys_wdata,
  input wire logic [31:0] sys_rdata,
  input wire logic sys_done
);

  typedef struct packed {
    logic [1:0] rx_sync;
    logic [1:0] tx_sync;
    logic [31:0] rx_current_pointer;
    logic [31:0] rx_next_pointer;
    logic [31:0] tx_current_pointer;
    logic [31:0] tx_next_pointer;
    logic [15:0] rx_current_count;
    logic [15:0] rx_next_count;
    logic [15:0] tx_current_count;
    logic [15:0] tx_next_count;
    logic rx_on;
    logic tx_on;
    logic [1:0] rx_size;
    logic [1:0] tx_size;
    logic rx_pend;
    logic tx_pend;
    logic rx_first;
    logic cur_tx;
    cpdma_state_t state;
    logic [31:0] data;
    logic aw_held;
    logic [11:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rx_eob;
    logic tx_eob;
  } cpdma_regs_t;

  cpdma_regs_t r;
  cpdma_regs_t next_r;

  function automatic logic [31:0] cpdma_step(input logic [1:0] sz);
    case (sz)
      CPDMA_SIZE_HALF: cpdma_step = 32'h0000_0002;
      CPDMA_SIZE_WORD: cpdma_step = 32'h0000_0004;
      default: cpdma_step = 32'h0000_0001;
    endcase
  endfunction

  function automatic logic [31:0] cpdma_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    cpdma_merge = res;
  endfunction

  logic rx_trig;
  logic tx_trig;
  logic do_write;
  logic do_read;
  logic wr_hit;
  logic [31:0] rd_val;
  logic [31:0] ctl;
  logic [31:0] pm;

  assign rx_trig = r.rx_sync[1];
  assign tx_trig = r.tx_sync[1];
  assign do_write = r.aw_held && r.w_held && !r.bvalid;
  assign do_read = s_axi_arvalid && !r.rvalid;
  assign ctl = r.w_data & {{8{r.w_strb[3]}}, {8{r.w_strb[2]}}, {8{r.w_strb[1]}}, {8{r.w_strb[0]}}};

  always_comb begin
    wr_hit = 1'b1;
    case (s_axi_araddr)
      CPDMA_OFF_RX_CUR_PTR: rd_val = r.rx_current_pointer;
      CPDMA_OFF_RX_CUR_CNT: rd_val = {16'h0000, r.rx_current_count};
      CPDMA_OFF_TX_CUR_PTR: rd_val = r.tx_current_pointer;
      CPDMA_OFF_TX_CUR_CNT: rd_val = {16'h0000, r.tx_current_count};
      CPDMA_OFF_RX_NXT_PTR: rd_val = r.rx_next_pointer;
      CPDMA_OFF_RX_NXT_CNT: rd_val = {16'h0000, r.rx_next_count};
      CPDMA_OFF_TX_NXT_PTR: rd_val = r.tx_next_pointer;
      CPDMA_OFF_TX_NXT_CNT: rd_val = {16'h0000, r.tx_next_count};
      CPDMA_OFF_CTRL: rd_val = 32'h0000_0000; // write-only
      CPDMA_OFF_STATUS: begin
        rd_val = 32'h0000_0000;
        rd_val[CPDMA_BIT_RX_ON] = r.rx_on;
        rd_val[CPDMA_BIT_TX_ON] = r.tx_on;
      end
      CPDMA_OFF_SIZE: rd_val = {28'h0000000, r.tx_size, r.rx_size};
      default: begin
        rd_val = 32'h0000_0000;
        wr_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_r = r;
    pm = 32'h0000_0000;
    // two-flop synchronisers on the peripheral triggers
    next_r.rx_sync = {r.rx_sync[0], rx_ready_trigger};
    next_r.tx_sync = {r.tx_sync[0], tx_ready_trigger};

    // axi4-lite write channel capture, either order
    if (s_axi_awvalid && !r.aw_held) begin
      next_r.aw_held = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.w_held) begin
      next_r.w_held = 1'b1;
      next_r.w_data = s_axi_wdata;
      next_r.w_strb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (do_read) begin
      next_r.rvalid = 1'b1;
      next_r.rdata = rd_val;
      next_r.rresp = wr_hit ? CPDMA_RESP_OKAY : CPDMA_RESP_SLVERR;
    end

    // engine: transfers run first so a register write in the same cycle wins
    case (r.state)
      CPDMA_IDLE: begin
        // rx before tx when both wait; a single pair so no peer arbitration
        if (r.rx_pend) begin
          next_r.cur_tx = 1'b0;
          next_r.state = CPDMA_BUS_REQ;
        end else if (r.tx_pend) begin
          next_r.cur_tx = 1'b1;
          next_r.state = CPDMA_BUS_REQ;
        end
      end
      CPDMA_BUS_REQ: begin
        if (sys_bus_grant) begin
          next_r.state = CPDMA_RD;
        end
      end
      CPDMA_RD: begin
        if (sys_done) begin
          next_r.data = sys_rdata;
          next_r.state = CPDMA_WR;
        end
      end
      CPDMA_WR: begin
        if (sys_done) begin
          next_r.state = CPDMA_DONE;
        end
      end
      CPDMA_DONE: begin
        next_r.state = CPDMA_IDLE;
        if (!r.cur_tx) begin
          next_r.rx_pend = 1'b0;
          next_r.rx_current_pointer = r.rx_current_pointer + cpdma_step(r.rx_size);
          next_r.rx_current_count = r.rx_current_count - 16'h0001;
          if (r.rx_current_count == 16'h0001) begin
            next_r.rx_eob = 1'b1;
            if (r.rx_next_count != 16'h0000) begin
              next_r.rx_current_pointer = r.rx_next_pointer;
              next_r.rx_current_count = r.rx_next_count;
              next_r.rx_next_count = CPDMA_CNT_RESET;
            end
          end
        end else begin
          next_r.tx_pend = 1'b0;
          next_r.tx_current_pointer = r.tx_current_pointer + cpdma_step(r.tx_size);
          next_r.tx_current_count = r.tx_current_count - 16'h0001;
          if (r.tx_current_count == 16'h0001) begin
            next_r.tx_eob = 1'b1;
            if (r.tx_next_count != 16'h0000) begin
              next_r.tx_current_pointer = r.tx_next_pointer;
              next_r.tx_current_count = r.tx_next_count;
              next_r.tx_next_count = CPDMA_CNT_RESET;
            end
          end
        end
      end
      default: next_r.state = CPDMA_IDLE;
    endcase

    // trigger capture: ignored once the channel has nothing left
    if (rx_trig && r.rx_on && r.rx_current_count != 16'h0000 && r.state == CPDMA_IDLE
        && !r.rx_pend) begin
      next_r.rx_pend = 1'b1;
    end
    if (tx_trig && r.tx_on && r.tx_current_count != 16'h0000 && r.state == CPDMA_IDLE
        && !r.tx_pend) begin
      next_r.tx_pend = 1'b1;
    end

    // register writes
    if (do_write) begin
      next_r.aw_held = 1'b0;
      next_r.w_held = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = CPDMA_RESP_OKAY;
      case (r.aw_addr)
        CPDMA_OFF_RX_CUR_PTR: begin
          next_r.rx_current_pointer = cpdma_merge(r.rx_current_pointer, r.w_data, r.w_strb);
        end
        CPDMA_OFF_TX_CUR_PTR: begin
          next_r.tx_current_pointer = cpdma_merge(r.tx_current_pointer, r.w_data, r.w_strb);
        end
        CPDMA_OFF_RX_NXT_PTR: begin
          next_r.rx_next_pointer = cpdma_merge(r.rx_next_pointer, r.w_data, r.w_strb);
        end
        CPDMA_OFF_TX_NXT_PTR: begin
          next_r.tx_next_pointer = cpdma_merge(r.tx_next_pointer, r.w_data, r.w_strb);
        end
        CPDMA_OFF_RX_CUR_CNT: begin
          pm = cpdma_merge({16'h0000, r.rx_current_count}, r.w_data, r.w_strb);
          next_r.rx_current_count = pm[15:0];
          next_r.rx_eob = 1'b0;
        end
        CPDMA_OFF_TX_CUR_CNT: begin
          pm = cpdma_merge({16'h0000, r.tx_current_count}, r.w_data, r.w_strb);
          next_r.tx_current_count = pm[15:0];
          next_r.tx_eob = 1'b0;
        end
        CPDMA_OFF_RX_NXT_CNT: begin
          pm = cpdma_merge({16'h0000, r.rx_next_count}, r.w_data, r.w_strb);
          next_r.rx_next_count = pm[15:0];
          next_r.rx_eob = 1'b0;
        end
        CPDMA_OFF_TX_NXT_CNT: begin
          pm = cpdma_merge({16'h0000, r.tx_next_count}, r.w_data, r.w_strb);
          next_r.tx_next_count = pm[15:0];
          next_r.tx_eob = 1'b0;
        end
        CPDMA_OFF_CTRL: begin
          // off beats on in the same write; zero bits leave state alone
          if (ctl[CPDMA_BIT_RX_OFF]) begin
            next_r.rx_on = 1'b0;
          end else if (ctl[CPDMA_BIT_RX_ON]) begin
            next_r.rx_on = 1'b1;
          end
          if (ctl[CPDMA_BIT_TX_OFF]) begin
            next_r.tx_on = 1'b0;
          end else if (ctl[CPDMA_BIT_TX_ON]) begin
            next_r.tx_on = 1'b1;
          end
        end
        CPDMA_OFF_SIZE: begin
          if (r.w_strb[0]) begin
            next_r.rx_size = r.w_data[CPDMA_BIT_RX_SIZE +: 2];
            next_r.tx_size = r.w_data[CPDMA_BIT_TX_SIZE +: 2];
          end
        end
        CPDMA_OFF_STATUS: next_r.bresp = CPDMA_RESP_OKAY;
        default: next_r.bresp = CPDMA_RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.state <= CPDMA_IDLE;
      r.rx_current_pointer <= CPDMA_PTR_RESET;
      r.tx_current_pointer <= CPDMA_PTR_RESET;
      r.rx_next_pointer <= CPDMA_PTR_RESET;
      r.tx_next_pointer <= CPDMA_PTR_RESET;
      r.rx_size <= CPDMA_SIZE_RESET;
      r.tx_size <= CPDMA_SIZE_RESET;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  // a channel only moves while a transfer is pending or in flight; disabling it
  // stops new captures, so pointer and count freeze for a consistent two-register read once any pending transfer is done
  assign s_axi_awready = !r.aw_held;
  assign s_axi_wready = !r.w_held;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;

  assign rx_end_of_buffer = r.rx_current_count == 16'h0000;
  assign rx_buffers_full = (r.rx_current_count == 16'h0000)
                           && (r.rx_next_count == 16'h0000);
  assign tx_end_of_buffer = r.tx_current_count == 16'h0000;
  assign tx_buffers_empty = (r.tx_current_count == 16'h0000)
                            && (r.tx_next_count == 16'h0000);

  assign sys_bus_req = r.state == CPDMA_BUS_REQ || r.state == CPDMA_RD || r.state == CPDMA_WR;
  assign sys_rd = r.state == CPDMA_RD;
  assign sys_wr = r.state == CPDMA_WR;
  // rx reads the peripheral first, tx writes it last
  assign sys_periph = r.cur_tx ? (r.state == CPDMA_WR) : (r.state == CPDMA_RD);
  assign sys_addr = r.cur_tx ? r.tx_current_pointer : r.rx_current_pointer;
  assign sys_size = r.cur_tx ? r.tx_size : r.rx_size;
  assign sys_wdata = r.data;
endmodule // cpdma_top

// ### verification/cpdma_checker.sv
// cpdma_checker: port-level checks on cpdma_top, bound to every instance.
// assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module cpdma_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic rx_end_of_buffer,
  input wire logic rx_buffers_full,
  input wire logic tx_end_of_buffer,
  input wire logic tx_buffers_empty,
  input wire logic sys_bus_req,
  input wire logic sys_bus_grant,
  input wire logic sys_rd,
  input wire logic sys_wr,
  input wire logic sys_periph,
  input wire logic sys_done
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_rd_held: assert property (sys_rd && !sys_done |=> sys_rd)
    else $error("bus read dropped before done");
  a_rd_after_grant: assert property ($rose(sys_rd) |-> $past(sys_bus_grant) && sys_bus_req)
    else $error("bus read without grant");
  a_wr_after_rd: assert property ($rose(sys_wr) |-> $past(sys_rd && sys_done))
    else $error("bus write without finished read");
  a_dir_swap: assert property ($rose(sys_wr) |-> sys_periph != $past(sys_periph))
    else $error("read and write target the same side");
  a_no_overlap: assert property (!(sys_rd && sys_wr))
    else $error("read and write at once");
  a_full_end: assert property (rx_buffers_full |-> rx_end_of_buffer)
    else $error("rx full without end flag");
  a_empty_end: assert property (tx_buffers_empty |-> tx_end_of_buffer)
    else $error("tx empty without end flag");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("register read not answered");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_grant_bound: assert property ($rose(sys_bus_req) |-> ##[1:20] sys_rd)
    else $error("bus read late after request");
endmodule // cpdma_checker
bind cpdma_top cpdma_checker chk_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .rx_end_of_buffer(rx_end_of_buffer), .rx_buffers_full(rx_buffers_full),
  .tx_end_of_buffer(tx_end_of_buffer), .tx_buffers_empty(tx_buffers_empty),
  .sys_bus_req(sys_bus_req), .sys_bus_grant(sys_bus_grant), .sys_rd(sys_rd),
  .sys_wr(sys_wr), .sys_periph(sys_periph), .sys_done(sys_done));

// ### verification/cpdma_sys_model.sv
// cpdma_sys_model: system bus memory plus the peripheral holding register.
// assumes the engine holds sys_rd/sys_wr until it samples sys_done.
`timescale 1ns/1ps
module cpdma_sys_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic [31:0] rx_hold,
  input wire logic sys_bus_req,
  output logic sys_bus_grant,
  input wire logic sys_rd,
  input wire logic sys_wr,
  input wire logic sys_periph,
  input wire logic [31:0] sys_addr,
  input wire logic [31:0] sys_wdata,
  output logic [31:0] sys_rdata,
  output logic sys_done,
  output logic wr_seen,
  output logic [64:0] wr_note
);
  logic [2:0] wait_cnt;
  always_ff @(posedge aclk) begin
    sys_done <= 1'b0;
    wr_seen <= 1'b0;
    // data lines toggle outside the answer cycle so stale data is never reused
    sys_rdata <= ~sys_rdata;
    if (!aresetn) begin
      sys_bus_grant <= 1'b0;
      wait_cnt <= 3'h0;
      sys_rdata <= 32'h0;
    end else begin
      sys_bus_grant <= sys_bus_req;
      if ((sys_rd || sys_wr) && !sys_done) begin
        wait_cnt <= wait_cnt + 3'h1;
        if (wait_cnt >= (slow ? 3'h3 : 3'h0)) begin
          sys_done <= 1'b1;
          wait_cnt <= 3'h0;
          sys_rdata <= sys_periph ? rx_hold : {sys_addr[15:0], ~sys_addr[15:0]};
          wr_seen <= sys_wr;
          wr_note <= {sys_periph, sys_periph ? 32'h0 : sys_addr, sys_wdata};
        end
      end
    end
  end
endmodule // cpdma_sys_model

// ### verification/cpdma_top_bench.sv
// cpdma_top_bench: self-checking bench for the channel-pair dma engine.
// assumes cpdma_pkg and cpdma_sys_model; byte strobes held on, clk_en low only in the rx chain test.
`timescale 1ns/1ps
module cpdma_top_bench;
  import cpdma_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rx_hold = 32'h0, rdata, sys_addr, sys_wdata, sys_rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic rx_trig = 1'b0, tx_trig = 1'b0, slow = 1'b0, clk_en = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, rx_end, rx_full, tx_end, tx_empty;
  logic bus_req, bus_grant, sys_rd, sys_wr, sys_periph, sys_done, wr_seen;
  logic [1:0] bresp, rresp, sys_size;
  logic [64:0] wr_note;
  logic [64:0] exp_q[$];
  int fail_count = 0;
  int n_tests = 0;
  always #10 aclk = ~aclk;
  cpdma_top dut_u (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_ready_trigger(rx_trig), .tx_ready_trigger(tx_trig), .rx_end_of_buffer(rx_end),
    .rx_buffers_full(rx_full), .tx_end_of_buffer(tx_end), .tx_buffers_empty(tx_empty),
    .sys_bus_req(bus_req), .sys_bus_grant(bus_grant), .sys_rd(sys_rd), .sys_wr(sys_wr),
    .sys_periph(sys_periph), .sys_addr(sys_addr), .sys_size(sys_size),
    .sys_wdata(sys_wdata), .sys_rdata(sys_rdata), .sys_done(sys_done));
  cpdma_sys_model sys_u (.aclk(aclk), .aresetn(aresetn), .slow(slow), .rx_hold(rx_hold),
    .sys_bus_req(bus_req), .sys_bus_grant(bus_grant), .sys_rd(sys_rd), .sys_wr(sys_wr),
    .sys_periph(sys_periph), .sys_addr(sys_addr), .sys_wdata(sys_wdata),
    .sys_rdata(sys_rdata), .sys_done(sys_done), .wr_seen(wr_seen), .wr_note(wr_note));
  function automatic logic [31:0] mem(input logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction
  task automatic chk(input string what, input logic [64:0] e, input logic [64:0] got);
    n_tests++;
    if (got !== e) begin
      $display("Error %s expected %h seen %h", what, e, got);
      fail_count++;
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic hang(input string what);
    $display("Error %s expected done seen timeout", what);
    fail_count++;
    give_verdict();
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      bready <= bvalid && !bready;
      if (++n > 50) hang("write");
    end while (!(bvalid && bready));
    chk("bresp", 65'(er), 65'(bresp));
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      rready <= rvalid && !rready;
      if (++n > 50) hang("read");
    end while (!(rvalid && rready));
    chk($sformatf("reg %h", a), 65'(e), 65'(rdata));
    chk("rresp", 65'(er), 65'(rresp));
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0) begin
      @(posedge aclk);
      if (++n > 400) hang("drain");
    end
    repeat (20) @(posedge aclk);
  endtask
  always @(posedge aclk) begin
    if (wr_seen && exp_q.size() == 0) begin
      $display("Error bus write expected none seen %h", wr_note);
      fail_count++;
    end else if (wr_seen) chk("bus write", exp_q.pop_front(), wr_note);
  end
  initial begin
    logic [31:0] p, h, t;
    void'($urandom(97024));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 11; i++) rd(12'h100 + 12'(4 * i), 32'h0, CPDMA_RESP_OKAY);
    chk("flags", 65'(4'hf), 65'({rx_end, rx_full, tx_end, tx_empty}));
    wr(12'h200, 32'hffff_ffff, CPDMA_RESP_SLVERR);
    rd(12'h200, 32'h0, CPDMA_RESP_SLVERR);
    $display("test reset and map done");
    p = $urandom;
    h = $urandom;
    rx_hold <= h;
    wr(CPDMA_OFF_RX_CUR_PTR, p, CPDMA_RESP_OKAY);
    wr(CPDMA_OFF_RX_CUR_CNT, 32'h2, CPDMA_RESP_OKAY);
    chk("rx flags", 65'(0), 65'({rx_end, rx_full}));
    wr(CPDMA_OFF_RX_NXT_PTR, p + 32'h40, CPDMA_RESP_OKAY);
    wr(CPDMA_OFF_RX_NXT_CNT, 32'h1, CPDMA_RESP_OKAY);
    exp_q = '{{1'b0, p, h}, {1'b0, p + 32'h1, h}, {1'b0, p + 32'h40, h}};
    wr(CPDMA_OFF_CTRL, 32'h1, CPDMA_RESP_OKAY);
    // with the clock enable low not even the trigger synchroniser may move
    clk_en <= 1'b0;
    rx_trig <= 1'b1;
    repeat (6) @(posedge aclk);
    chk("frozen bus request", 65'(0), 65'(bus_req));
    clk_en <= 1'b1;
    drain();
    rx_trig <= 1'b0;
    rd(CPDMA_OFF_RX_CUR_PTR, p + 32'h41, CPDMA_RESP_OKAY);
    rd(CPDMA_OFF_RX_NXT_CNT, 32'h0, CPDMA_RESP_OKAY);
    chk("rx flags", 65'(2'h3), 65'({rx_end, rx_full}));
    $display("test rx chain done");
    slow <= 1'b1;
    for (int s = 1; s < 3; s++) begin
      p = $urandom;
      wr(CPDMA_OFF_SIZE, 32'(s) << CPDMA_BIT_TX_SIZE, CPDMA_RESP_OKAY);
      wr(CPDMA_OFF_TX_CUR_PTR, p, CPDMA_RESP_OKAY);
      wr(CPDMA_OFF_TX_CUR_CNT, 32'h2, CPDMA_RESP_OKAY);
      t = p + (32'h1 << s);
      exp_q = '{{1'b1, 32'h0, mem(p)}, {1'b1, 32'h0, mem(t)}};
      tx_trig <= 1'b1;
      wr(CPDMA_OFF_CTRL, 32'h100, CPDMA_RESP_OKAY);
      drain();
      chk("bus size", 65'(s), 65'(sys_size));
      t = t + (32'h1 << s);
      rd(CPDMA_OFF_TX_CUR_PTR, t, CPDMA_RESP_OKAY);
      chk("tx flags", 65'(2'h3), 65'({tx_end, tx_empty}));
    end
    $display("test tx sizes done");
    slow <= 1'b0;
    p = $urandom;
    wr(CPDMA_OFF_CTRL, 32'h202, CPDMA_RESP_OKAY);
    wr(CPDMA_OFF_RX_CUR_PTR, p, CPDMA_RESP_OKAY);
    wr(CPDMA_OFF_RX_CUR_CNT, 32'h1, CPDMA_RESP_OKAY);
    wr(CPDMA_OFF_TX_CUR_CNT, 32'h3, CPDMA_RESP_OKAY);
    rx_trig <= 1'b1;
    wr(CPDMA_OFF_CTRL, 32'h303, CPDMA_RESP_OKAY);
    repeat (30) @(posedge aclk);
    rd(CPDMA_OFF_STATUS, 32'h0, CPDMA_RESP_OKAY);
    rd(CPDMA_OFF_TX_CUR_CNT, 32'h3, CPDMA_RESP_OKAY);
    exp_q = '{{1'b0, p, h}, {1'b1, 32'h0, mem(t)}, {1'b1, 32'h0, mem(t + 32'h4)},
      {1'b1, 32'h0, mem(t + 32'h8)}};
    wr(CPDMA_OFF_CTRL, 32'h101, CPDMA_RESP_OKAY);
    wr(CPDMA_OFF_CTRL, 32'h0, CPDMA_RESP_OKAY);
    rd(CPDMA_OFF_STATUS, 32'h101, CPDMA_RESP_OKAY);
    drain();
    rx_trig <= 1'b0;
    tx_trig <= 1'b0;
    $display("test disable and priority done");
    give_verdict();
  end
endmodule // cpdma_top_bench
